// ### hw/epp_params.svh
// Constants of the parallel programming port
`ifndef EPP_PARAMS_SVH
`define EPP_PARAMS_SVH
`define EPP_DATA_W      8
`define EPP_REG_CNT     8
`define EPP_REG_RST     8'h00
`define EPP_STATUS_IDX  3'h7
`endif

// ### hw/epp_pkg.sv
// Types of the parallel programming port
`include "epp_params.svh"
package epp_pkg;
  typedef struct packed {
    logic ale;
    logic rd_n;
    logic wr_n;
    logic cs_n;
    logic rst;
  } epp_ctrl_t;
  typedef struct packed {
    logic [`EPP_DATA_W-1:0] data;
    logic                   oe;
  } epp_bus_out_t;
  typedef enum logic [1:0] {
    EPP_IDLE  = 2'b00,
    EPP_READ  = 2'b01,
    EPP_WRITE = 2'b10,
    EPP_DONE  = 2'b11
  } epp_state_t;
endpackage

// ### hw/epp_port.sv
// Parallel programming port: pin synchroniser, address latch and register file
`timescale 1ns/1ps
`default_nettype none
`include "epp_params.svh"

module epp_port #(
  parameter int REG_CNT = `EPP_REG_CNT
) (
  input  wire logic                           ref_clk,
  input  wire logic                           rst,
  input  wire epp_pkg::epp_ctrl_t             ctrl_pins,
  input  wire logic [`EPP_DATA_W-1:0]         bus_in,
  output var  epp_pkg::epp_bus_out_t          bus_out,
  output var  logic [REG_CNT*`EPP_DATA_W-1:0] reg_image,
  input  wire logic [`EPP_DATA_W-1:0]         array_data,
  output var  logic                           write_pulse
);
  import epp_pkg::*;

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  localparam int AW = $clog2(REG_CNT);

  // The index travels on the byte-wide bus, so more registers are unreachable
  if (REG_CNT < 2 || REG_CNT > 256) begin : g_bad_reg_range
    $error("REG_CNT must lie between 2 and 256");
  end

  // Addresses wrap on their low bits, which needs a power of two
  if ((REG_CNT & (REG_CNT - 1)) != 0) begin : g_bad_reg_pow2
    $error("REG_CNT must be a power of two");
  end

  if (AW > `EPP_DATA_W) begin : g_bad_addr_width
    $error("register index wider than the bus");
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // A low strobe only counts together with a low select
  function automatic logic strobe_active(input logic sel_n, input logic strobe_n);
    return !sel_n && !strobe_n;
  endfunction

  // The top index keeps stores, but a read of it returns the array byte for verification
  function automatic logic is_array_index(input logic [AW-1:0] idx);
    return idx == AW'(REG_CNT - 1);
  endfunction

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  // Bus and strobes follow the programmer's own timing; three stages each,
  // and a level counts once stages two and three agree.
  epp_ctrl_t              c1;
  epp_ctrl_t              c2;
  epp_ctrl_t              c3;
  epp_ctrl_t              cq;
  logic [`EPP_DATA_W-1:0] d1;
  logic [`EPP_DATA_W-1:0] d2;
  logic [`EPP_DATA_W-1:0] d3;
  logic [`EPP_DATA_W-1:0] dq;

  always_ff @(posedge ref_clk) begin
    c1 <= ctrl_pins;
    c2 <= c1;
    c3 <= c2;
  end

  always_ff @(posedge ref_clk) begin
    d1 <= bus_in;
    d2 <= d1;
    d3 <= d2;
  end

  // No reset here: the stages keep following the pins through reset
  always_ff @(posedge ref_clk) begin
    if (c2 == c3) begin
      cq <= c3;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (d2 == d3) begin
      dq <= d3;
    end
  end

  // ----------------------------------------------------------------
  // Reset
  // ----------------------------------------------------------------
  // The programming reset is a pin, so it is taken after qualification
  logic prst;

  assign prst = rst | cq.rst;

  // ----------------------------------------------------------------
  // Address latch
  // ----------------------------------------------------------------
  // The bus passes the same stages as the strobe, so the held byte is the
  // address that stood while the strobe was high.
  logic                   ale_prev;
  logic [`EPP_DATA_W-1:0] addr_hold;
  logic [AW-1:0]          addr;

  // Cleared to the strobe's idle level, so no false falling edge after reset
  always_ff @(posedge ref_clk) begin
    if (prst) begin
      ale_prev <= 1'b0;
    end else begin
      ale_prev <= cq.ale;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (prst) begin
      addr_hold <= '0;
    end else if (cq.ale) begin
      addr_hold <= dq;
    end
  end

  // Addresses beyond the register count wrap onto their low bits
  always_ff @(posedge ref_clk) begin
    if (prst) begin
      addr <= '0;
    end else if (ale_prev && !cq.ale) begin
      addr <= addr_hold[AW-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Access sequencer
  // ----------------------------------------------------------------
  epp_state_t state;
  epp_state_t next_state;
  logic       rd_req;
  logic       wr_req;

  assign rd_req = strobe_active(cq.cs_n, cq.rd_n);
  assign wr_req = strobe_active(cq.cs_n, cq.wr_n);

  // One store per access: a new one needs the strobe or the select released
  always_comb begin
    next_state = state;
    case (state)
      EPP_IDLE: begin
        if (rd_req) begin
          next_state = EPP_READ;
        end else if (wr_req) begin
          next_state = EPP_WRITE;
        end
      end
      EPP_READ: begin
        if (!rd_req) begin
          next_state = EPP_IDLE;
        end
      end
      EPP_WRITE: begin
        next_state = EPP_DONE;
      end
      EPP_DONE: begin
        if (!wr_req) begin
          next_state = EPP_IDLE;
        end
      end
      default: begin
        next_state = EPP_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (prst) begin
      state <= EPP_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  // A store to the top index is kept but never read back
  logic [`EPP_DATA_W-1:0] regs [REG_CNT];

  always_ff @(posedge ref_clk) begin
    if (prst) begin
      for (int i = 0; i < REG_CNT; i++) begin
        regs[i] <= `EPP_REG_RST;
      end
    end else if (state == EPP_WRITE) begin
      regs[addr] <= dq;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (prst) begin
      write_pulse <= 1'b0;
    end else begin
      write_pulse <= (state == EPP_WRITE);
    end
  end

  always_comb begin
    for (int i = 0; i < REG_CNT; i++) begin
      reg_image[i*`EPP_DATA_W +: `EPP_DATA_W] = regs[i];
    end
  end

  // ----------------------------------------------------------------
  // Bus driver
  // ----------------------------------------------------------------
  // Driving only in the read state keeps the bus free for addresses and data
  always_ff @(posedge ref_clk) begin
    if (prst) begin
      bus_out <= '0;
    end else begin
      bus_out.oe <= (state == EPP_READ) && rd_req;
      if (is_array_index(addr)) begin
        bus_out.data <= array_data;
      end else begin
        bus_out.data <= regs[addr];
      end
    end
  end

endmodule // epp_port
`default_nettype wire

// ### test/epp_port_monitor.sv
// Checker of the programming port pins
`timescale 1ns/1ps
`default_nettype none
module epp_port_monitor #(parameter int REG_CNT = 8) (
  input wire logic                  ref_clk,
  input wire logic                  rst,
  input wire epp_pkg::epp_ctrl_t    ctrl_pins,
  input wire epp_pkg::epp_bus_out_t bus_out,
  input wire logic [REG_CNT*8-1:0]  reg_image,
  input wire logic                  write_pulse
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_pin_reset: assert property (ctrl_pins.rst[*8] |-> reg_image == '0 && !bus_out.oe)
    else $error("pin reset left state");
  a_read_drive: assert property ((!ctrl_pins.rd_n && !ctrl_pins.cs_n)[*8] |-> bus_out.oe)
    else $error("read not driven");
  a_idle_float: assert property (ctrl_pins.rd_n[*8] |-> !bus_out.oe)
    else $error("bus driven while idle");
  a_select_gate: assert property (ctrl_pins.cs_n[*8] |-> !write_pulse)
    else $error("store while deselected");
  a_one_write: assert property (write_pulse |=> !write_pulse)
    else $error("double store");
  a_store_follows: assert property ($fell(ctrl_pins.wr_n) && !ctrl_pins.cs_n
    |-> ##[4:8] write_pulse) else $error("write access not stored");
  a_select_float: assert property (ctrl_pins.cs_n[*8] |-> !bus_out.oe)
    else $error("bus driven while deselected");
endmodule // epp_port_monitor
bind epp_port epp_port_monitor #(.REG_CNT(REG_CNT)) mon (.ref_clk(ref_clk), .rst(rst),
  .ctrl_pins(ctrl_pins), .bus_out(bus_out), .reg_image(reg_image), .write_pulse(write_pulse));
`default_nettype wire

// ### test/epp_prog.sv
// Programmer model driving the parallel pins
`timescale 1ns/1ps
`default_nettype none
module epp_prog (
  input  wire logic           ref_clk,
  input  wire logic [7:0]     bus,
  output var  epp_pkg::epp_ctrl_t pins,
  output var  logic           drv,
  output var  logic [7:0]     val
);
  initial {pins, drv, val} = {5'h0E, 1'b0, 8'h00};
  // Each level held ten cycles, well over the synchroniser need
  task step(input logic [4:0] c, input logic d, input logic [7:0] x);
    @(posedge ref_clk);
    pins <= c;
    drv <= d;
    val <= x;
    repeat (9) @(posedge ref_clk);
  endtask
  task acc(input logic w, cs, input logic [7:0] a, x, output logic [7:0] r);
    step(5'h1E, 1'b1, a);
    step(5'h0E, 1'b1, a);
    step({1'b0, w, ~w, cs, 1'b0}, w, x);
    @(negedge ref_clk);
    r = bus;
    step(5'h0E, 1'b0, x);
  endtask
endmodule // epp_prog
`default_nettype wire

// ### test/epp_port_bench.sv
// Self-checking bench of the programming port
`timescale 1ns/1ps
`default_nettype none
module epp_port_bench;
  import epp_pkg::*;
  logic ref_clk = 0, rst = 1, drv, write_pulse;
  logic [7:0] val, bus_in, r, array_data = 8'h00;
  int mdl[8];
  int rd_q[$];
  int n_stores = 0;
  logic [15:0] lfsr = 16'h27FF;
  logic [63:0] reg_image;
  epp_ctrl_t pins;
  epp_bus_out_t bus_out;
  int miscompares = 0, n_compared = 0;
  always #12.5 ref_clk = ~ref_clk;
  // Released bus floats high on the pull-ups
  assign bus_in = bus_out.oe ? bus_out.data : drv ? val : 8'hFF;
  epp_prog p (.ref_clk(ref_clk), .bus(bus_in), .pins(pins), .drv(drv), .val(val));
  epp_port uut (.ref_clk(ref_clk), .rst(rst), .ctrl_pins(pins), .bus_in(bus_in),
    .bus_out(bus_out), .reg_image(reg_image), .array_data(array_data),
    .write_pulse(write_pulse));
  task chk(input logic [7:0] g, e);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %0t: got %h want %h", $time, g, e);
    end
  endtask
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  always @(posedge ref_clk) begin
    if (write_pulse === 1'b1) n_stores++;
  end
  task conclude;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #100us;
    miscompares++;
    conclude;
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      lfsr = lfsr_next(lfsr);
      mdl[i] = lfsr[7:0];
      array_data <= lfsr[15:8];
      p.acc(1'b1, 1'b0, 8'(i), 8'(mdl[i]), r);
      chk(reg_image[i*8+:8], 8'(mdl[i]));
    end
    chk(8'(n_stores), 8'h08);
    for (int i = 0; i < 8; i++) begin
      rd_q.push_back(i == 7 ? int'(array_data) : mdl[i]);
      p.acc(1'b0, 1'b0, 8'(i), 8'h00, r);
      chk(r, 8'(rd_q.pop_front()));
    end
    p.acc(1'b1, 1'b1, 8'h03, ~8'(mdl[3]), r);
    chk(reg_image[31:24], 8'(mdl[3]));
    chk(8'(n_stores), 8'h08);
    p.acc(1'b0, 1'b1, 8'h03, 8'h00, r);
    chk(r, 8'hFF);
    p.step(5'h0F, 1'b0, 8'h00);
    p.step(5'h0E, 1'b0, 8'h00);
    chk({7'h00, reg_image == 64'h0}, 8'h01);
    conclude;
  end
endmodule // epp_port_bench
`default_nettype wire
